// ===== hdl/phy_status_regs.sv
`default_nettype none
// Function
// RULE1 - Report lane B/A skew at 7:4, 3:0
// RULE2 - Strap word one bits 15..12
// RULE3 - Crossover, wiring, duplex straps at 10..8
// RULE4 - Bit 7 set when autoneg strapped off
// RULE5 - Large package speed 6:5, address 4:0
// RULE6 - Small package speed bit 5, address 3:0
// RULE7 - Word two bit 10 quick drop strap
// RULE8 - Small package skew straps 6:4, 2:0
// RULE9 - Sixteen-bit received byte count, reset zero
// RULE10 - Byte count saturates when wrap select zero
// RULE11 - Eight-bit error count, saturates likewise
// RULE12 - Write bit 0 locks readable counts
// RULE13 - Write bit 1 locks, then clears live counts and overflow flags
// RULE14 - Readable byte count holds last lock
// RULE15 - Bit 10 sticky packet overflow flag
// RULE16 - Bit 9 sticky byte overflow flag
// RULE17 - Straps caught once after reset release
module phy_status_regs
  import phy_status_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Management register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Strap pins
  input wire strap_t STRAPS,
  // Receive alignment status from the datapath
  input wire logic [3:0] LANE_A_ALIGN_CYCLES,
  input wire logic [3:0] LANE_B_ALIGN_CYCLES,
  // Checker events and count mode
  input wire checker_evt_t CHECKER_EVT,
  input wire logic TALLY_WRAP_SELECT,
  // Interrupt
  output logic IRQ
);

  strap_t strap_meta;
  strap_t strap_sync;
  strap_t strap_held;
  logic strap_taken;
  logic [1:0] strap_fill;
  logic [15:0] checker_bytes_seen;
  logic [7:0] checker_bad_bytes;
  logic [15:0] byte_shown;
  logic [7:0] bad_shown;
  logic packet_tally_overflow;
  logic byte_tally_overflow;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic do_lock;
  logic do_clear;
  logic byte_wrap;
  logic pkt_wrap;
  logic [15:0] word_skew;
  logic [15:0] word_one;
  logic [15:0] word_two;
  logic [15:0] next_rdata;

  // Strap pin synchroniser
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= STRAPS;
      strap_sync <= strap_meta;
    end
  end

  // Marks when the synchroniser holds real pin levels after release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_fill <= 2'b00;
    end else begin
      strap_fill <= {strap_fill[0], 1'b1};
    end
  end

  // Catch the straps once the pipeline is full, hold afterwards
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_held <= '0;
      strap_taken <= 1'b0;
    end else if (strap_fill[1] && !strap_taken) begin
      strap_held <= strap_sync; // RULE17
      strap_taken <= 1'b1;
    end
  end

  // Control strobes from the checker status register and wrap strobes from the checker events
  assign do_lock = WR && ADDR == OFF_ERR_OVF && (WDATA[LOCK_BIT] || WDATA[LOCK_CLEAR_BIT]);
  assign do_clear = WR && ADDR == OFF_ERR_OVF && WDATA[LOCK_CLEAR_BIT];
  assign byte_wrap = CHECKER_EVT.byte_seen && checker_bytes_seen == BYTE_COUNT_MAX;
  assign pkt_wrap = CHECKER_EVT.packet_wrap;

  // Live byte counter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      checker_bytes_seen <= BYTE_COUNT_RESET; // RULE9
    end else if (do_clear) begin
      checker_bytes_seen <= BYTE_COUNT_RESET; // RULE13
    end else if (CHECKER_EVT.byte_seen) begin
      if (checker_bytes_seen != BYTE_COUNT_MAX || TALLY_WRAP_SELECT) begin
        checker_bytes_seen <= checker_bytes_seen + 16'h0001; // RULE10
      end
    end
  end

  // Live error counter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      checker_bad_bytes <= ERR_COUNT_RESET;
    end else if (do_clear) begin
      checker_bad_bytes <= ERR_COUNT_RESET; // RULE13
    end else if (CHECKER_EVT.byte_bad) begin
      if (checker_bad_bytes != ERR_COUNT_MAX || TALLY_WRAP_SELECT) begin
        checker_bad_bytes <= checker_bad_bytes + 8'h01; // RULE11
      end
    end
  end

  // Snapshot taken on lock; the value before any clear is captured
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      byte_shown <= BYTE_COUNT_RESET;
      bad_shown <= ERR_COUNT_RESET;
    end else if (do_lock) begin
      byte_shown <= checker_bytes_seen; // RULE12 RULE14
      bad_shown <= checker_bad_bytes; // RULE12
    end
  end

  // Sticky overflow flags, cleared only by lock-and-clear; set wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      packet_tally_overflow <= 1'b0;
      byte_tally_overflow <= 1'b0;
    end else begin
      if (pkt_wrap) begin
        packet_tally_overflow <= 1'b1; // RULE15
      end else if (do_clear) begin
        packet_tally_overflow <= 1'b0; // RULE13
      end
      if (byte_wrap) begin
        byte_tally_overflow <= 1'b1; // RULE16
      end else if (do_clear) begin
        byte_tally_overflow <= 1'b0; // RULE13
      end
    end
  end

  // Interrupt status: write one to clear, set wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if ((i == IRQ_BYTE_OVF && byte_wrap) || (i == IRQ_PKT_OVF && pkt_wrap)) begin
          irq_status[i] <= 1'b1;
        end else if (WR && ADDR == OFF_IRQ_STATUS && WDATA[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask <= '0;
    end else if (WR && ADDR == OFF_IRQ_MASK) begin
      irq_mask <= WDATA[IRQ_BITS-1:0];
    end
  end

  // Interrupt output register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // Read words
  always_comb begin
    word_skew = 16'h0000;
    word_skew[7:4] = LANE_B_ALIGN_CYCLES; // RULE1
    word_skew[3:0] = LANE_A_ALIGN_CYCLES; // RULE1
    word_one = 16'h0000;
    word_one[15] = strap_held.mirror_en; // RULE2
    word_one[14] = strap_held.downshift_en; // RULE2
    word_one[13] = LARGE_PACKAGE ? strap_held.clock_output_off_strap : 1'b0; // RULE2
    word_one[12] = strap_held.reduced_iface_off_strap; // RULE2
    word_one[10] = strap_held.auto_crossover_off_strap; // RULE3
    word_one[9] = strap_held.forced_wiring_strap; // RULE3
    word_one[8] = strap_held.half_duplex_strap; // RULE3
    word_one[7] = strap_held.autoneg_off_strap; // RULE4
    word_two = 16'h0000;
    word_two[10] = strap_held.quick_drop_strap; // RULE7
    if (LARGE_PACKAGE) begin
      word_one[6:5] = strap_held.speed_choice_strap_pair; // RULE5
      word_one[4:0] = strap_held.mgmt_address_strap; // RULE5
    end else begin
      word_one[5] = strap_held.speed_choice_strap_pair[0]; // RULE6
      word_one[3:0] = strap_held.mgmt_address_strap[3:0]; // RULE6
      word_two[6:4] = strap_held.tx_skew_strap; // RULE8
      word_two[2:0] = strap_held.rx_skew_strap; // RULE8
    end
  end

  // Address decode for reads
  always_comb begin
    if (ADDR == OFF_SKEW) begin
      next_rdata = word_skew;
    end else if (ADDR == OFF_STRAP_ONE) begin
      next_rdata = word_one;
    end else if (ADDR == OFF_STRAP_TWO) begin
      next_rdata = word_two;
    end else if (ADDR == OFF_BYTE_COUNT) begin
      next_rdata = byte_shown; // RULE14
    end else if (ADDR == OFF_ERR_OVF) begin
      next_rdata = {5'h00, packet_tally_overflow, byte_tally_overflow, 1'b0, bad_shown};
    end else if (ADDR == OFF_IRQ_STATUS) begin
      next_rdata = {14'h0000, irq_status};
    end else if (ADDR == OFF_IRQ_MASK) begin
      next_rdata = {14'h0000, irq_mask};
    end else begin
      next_rdata = 16'h0000;
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // Assertions
  locked_count_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE14
    !do_lock |=> $stable(byte_shown))
    else $error("byte snapshot moved without lock");
  lock_capture_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE12
    do_lock |=> byte_shown == $past(checker_bytes_seen))
    else $error("lock missed value");
  clear_zeroes_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE13
    do_clear && !byte_wrap && !pkt_wrap |=> checker_bytes_seen == 16'h0000
    && checker_bad_bytes == 8'h00 && !byte_tally_overflow && !packet_tally_overflow)
    else $error("clear incomplete");
  byte_saturate_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE10
    checker_bytes_seen == BYTE_COUNT_MAX && !TALLY_WRAP_SELECT && !do_clear
    |=> checker_bytes_seen == BYTE_COUNT_MAX)
    else $error("byte count wrapped");
  err_saturate_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE11
    checker_bad_bytes == ERR_COUNT_MAX && !TALLY_WRAP_SELECT && !do_clear
    |=> checker_bad_bytes == ERR_COUNT_MAX)
    else $error("error count wrapped");
  pkt_flag_sticky_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE15
    packet_tally_overflow && !do_clear |=> packet_tally_overflow)
    else $error("packet flag dropped");
  byte_flag_set_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
    byte_wrap |=> byte_tally_overflow)
    else $error("byte flag not set");
  strap_frozen_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE17
    strap_taken |=> $stable(strap_held))
    else $error("straps changed");
  byte_count_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE9
    RD && ADDR == OFF_BYTE_COUNT |=> RDATA == $past(byte_shown))
    else $error("byte count read wrong");
  skew_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE1
    RD && ADDR == OFF_SKEW |=> RDATA[7:0] == $past({LANE_B_ALIGN_CYCLES, LANE_A_ALIGN_CYCLES})
    && RDATA[15:8] == 8'h00)
    else $error("skew read wrong");
  strap_top_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE2
    RD && ADDR == OFF_STRAP_ONE |=> RDATA[15] == $past(strap_held.mirror_en)
    && RDATA[14] == $past(strap_held.downshift_en)
    && RDATA[12] == $past(strap_held.reduced_iface_off_strap))
    else $error("strap word one top bits wrong");
  strap_mid_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE3
    RD && ADDR == OFF_STRAP_ONE |=> !RDATA[11]
    && RDATA[10] == $past(strap_held.auto_crossover_off_strap)
    && RDATA[9] == $past(strap_held.forced_wiring_strap)
    && RDATA[8] == $past(strap_held.half_duplex_strap))
    else $error("strap word one middle bits wrong");
  autoneg_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE4
    RD && ADDR == OFF_STRAP_ONE |=> RDATA[7] == $past(strap_held.autoneg_off_strap))
    else $error("autoneg strap bit wrong");
  large_layout_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE5
    LARGE_PACKAGE && RD && ADDR == OFF_STRAP_ONE
    |=> RDATA[13] == $past(strap_held.clock_output_off_strap)
    && RDATA[6:0] == $past({strap_held.speed_choice_strap_pair, strap_held.mgmt_address_strap}))
    else $error("large package strap layout wrong");
  small_layout_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE6
    !LARGE_PACKAGE && RD && ADDR == OFF_STRAP_ONE |=> !RDATA[13] && !RDATA[6] && !RDATA[4]
    && RDATA[5] == $past(strap_held.speed_choice_strap_pair[0])
    && RDATA[3:0] == $past(strap_held.mgmt_address_strap[3:0]))
    else $error("small package strap layout wrong");
  quick_drop_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE7
    RD && ADDR == OFF_STRAP_TWO |=> RDATA[15:11] == 5'h00 && RDATA[9:7] == 3'h0
    && RDATA[10] == $past(strap_held.quick_drop_strap) && !RDATA[3])
    else $error("strap word two upper bits wrong");
  large_skew_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE8
    LARGE_PACKAGE && RD && ADDR == OFF_STRAP_TWO |=> RDATA[6:4] == 3'h0 && RDATA[2:0] == 3'h0)
    else $error("skew straps shown on large package");
  small_skew_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE8
    !LARGE_PACKAGE && RD && ADDR == OFF_STRAP_TWO |=> RDATA[6:4] == $past(strap_held.tx_skew_strap)
    && RDATA[2:0] == $past(strap_held.rx_skew_strap))
    else $error("skew straps read wrong");
  byte_step_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE9
    CHECKER_EVT.byte_seen && !do_clear && checker_bytes_seen != BYTE_COUNT_MAX
    |=> checker_bytes_seen == $past(checker_bytes_seen) + 16'h0001)
    else $error("byte count did not step");
  byte_wrap_mode_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE10
    CHECKER_EVT.byte_seen && !do_clear && TALLY_WRAP_SELECT
    && checker_bytes_seen == BYTE_COUNT_MAX |=> checker_bytes_seen == BYTE_COUNT_RESET)
    else $error("byte count did not wrap");
  err_step_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE11
    CHECKER_EVT.byte_bad && !do_clear && checker_bad_bytes != ERR_COUNT_MAX
    |=> checker_bad_bytes == $past(checker_bad_bytes) + 8'h01)
    else $error("error count did not step");
  err_idle_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE11
    !CHECKER_EVT.byte_bad && !do_clear |=> $stable(checker_bad_bytes))
    else $error("error count moved without event");
  err_lock_capture_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE12
    do_lock |=> bad_shown == $past(checker_bad_bytes))
    else $error("lock missed error count");
  clear_locks_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE13
    do_clear |=> byte_shown == $past(checker_bytes_seen)
    && bad_shown == $past(checker_bad_bytes))
    else $error("clear did not lock first");
  pkt_flag_set_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE15
    pkt_wrap |=> packet_tally_overflow)
    else $error("packet flag not set");
  byte_flag_sticky_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
    byte_tally_overflow && !do_clear |=> byte_tally_overflow)
    else $error("byte flag dropped");
  flag_word_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE16
    RD && ADDR == OFF_ERR_OVF |=> RDATA[15:11] == 5'h00 && !RDATA[8]
    && RDATA[10] == $past(packet_tally_overflow) && RDATA[9] == $past(byte_tally_overflow)
    && RDATA[7:0] == $past(bad_shown))
    else $error("checker status read wrong");
  strap_capture_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE17
    strap_fill[1] && !strap_taken |=> strap_held == $past(strap_sync))
    else $error("straps not caught");
  strap_wait_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE17
    !strap_fill[1] |-> !strap_taken)
    else $error("straps caught before pipeline filled");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !RD |=> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  irq_status_set_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    byte_wrap |=> irq_status[IRQ_BYTE_OVF])
    else $error("interrupt status not set");
  irq_level_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    irq_status[IRQ_PKT_OVF] && irq_mask[IRQ_PKT_OVF] |=> IRQ)
    else $error("interrupt not raised");

endmodule // phy_status_regs
`default_nettype wire

// ===== hdl/phy_status_pkg.sv
`default_nettype none
package phy_status_pkg;
  // Register offsets (word index on the management port)
  localparam logic [7:0] OFF_SKEW = 8'h55;
  localparam logic [7:0] OFF_STRAP_ONE = 8'h6E;
  localparam logic [7:0] OFF_STRAP_TWO = 8'h6F;
  localparam logic [7:0] OFF_BYTE_COUNT = 8'h71;
  localparam logic [7:0] OFF_ERR_OVF = 8'h72;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h73;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h74;
  // Field positions
  localparam int LOCK_BIT = 0;
  localparam int LOCK_CLEAR_BIT = 1;
  localparam int PKT_OVF_BIT = 10;
  localparam int BYTE_OVF_BIT = 9;
  // Interrupt status bits
  localparam int IRQ_BYTE_OVF = 0;
  localparam int IRQ_PKT_OVF = 1;
  localparam int IRQ_BITS = 2;
  // Reset and saturation values
  localparam logic [15:0] BYTE_COUNT_RESET = 16'h0000;
  localparam logic [7:0] ERR_COUNT_RESET = 8'h00;
  localparam logic [15:0] BYTE_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] ERR_COUNT_MAX = 8'hFF;

  // Latched strap levels
  typedef struct packed {
    logic mirror_en;
    logic downshift_en;
    logic clock_output_off_strap;
    logic reduced_iface_off_strap;
    logic auto_crossover_off_strap;
    logic forced_wiring_strap;
    logic half_duplex_strap;
    logic autoneg_off_strap;
    logic [1:0] speed_choice_strap_pair;
    logic [4:0] mgmt_address_strap;
    logic quick_drop_strap;
    logic [2:0] tx_skew_strap;
    logic [2:0] rx_skew_strap;
  } strap_t;

  // Checker event inputs for one clock
  typedef struct packed {
    logic byte_seen;
    logic byte_bad;
    logic packet_wrap;
  } checker_evt_t;
endpackage
`default_nettype wire

// ===== bench/test_phy_status_regs.sv
`default_nettype none
module test_phy_status_regs
  import phy_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and observed signals
  logic clk, arst_n, wr, rd, wrap_sel, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d, e1, e2;
  logic [15:0] rdata_s, d2, e3, e4;
  logic [3:0] lane_a, lane_b;
  strap_t straps, s0;
  checker_evt_t evt;
  int err_count, compares;

  phy_status_regs uut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .STRAPS(straps), .LANE_A_ALIGN_CYCLES(lane_a),
    .LANE_B_ALIGN_CYCLES(lane_b), .CHECKER_EVT(evt), .TALLY_WRAP_SELECT(wrap_sel), .IRQ(irq));

  // Small package variant for the alternate strap layout
  phy_status_regs #(.LARGE_PACKAGE(1'b0)) uut_small (.CLK(clk), .ARST_N(arst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata_s), .STRAPS(straps),
    .LANE_A_ALIGN_CYCLES(lane_a), .LANE_B_ALIGN_CYCLES(lane_b), .CHECKER_EVT(evt),
    .TALLY_WRAP_SELECT(wrap_sel), .IRQ());

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read strobe, data sampled mid-cycle after the taking edge
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    d2 = rdata_s;
  endtask

  // Hold checker events for exactly n edges
  task automatic pulse(input int n, input checker_evt_t e);
    @(posedge clk);
    evt <= e;
    repeat (n) @(posedge clk);
    evt <= '0;
  endtask

  task automatic t_straps;
    e1 = {s0.mirror_en, s0.downshift_en, s0.clock_output_off_strap,
      s0.reduced_iface_off_strap, 1'b0, s0.auto_crossover_off_strap, s0.forced_wiring_strap,
      s0.half_duplex_strap, s0.autoneg_off_strap, s0.speed_choice_strap_pair,
      s0.mgmt_address_strap};
    e2 = {5'h00, s0.quick_drop_strap, 10'h000};
    e3 = {s0.mirror_en, s0.downshift_en, 1'b0, s0.reduced_iface_off_strap, 1'b0,
      s0.auto_crossover_off_strap, s0.forced_wiring_strap, s0.half_duplex_strap,
      s0.autoneg_off_strap, 1'b0, s0.speed_choice_strap_pair[0], 1'b0,
      s0.mgmt_address_strap[3:0]};
    e4 = {5'h00, s0.quick_drop_strap, 3'h0, s0.tx_skew_strap, 1'b0, s0.rx_skew_strap};
    reg_rd(8'h6E, d); chk(d, e1, "strap word one");
    chk(d2, e3, "small strap word one");
    reg_rd(8'h6F, d); chk(d, e2, "strap word two");
    chk(d2, e4, "small strap word two");
    straps <= ~s0;
    reg_wr(8'h6E, 16'hFFFF);
    reg_wr(8'h6F, 16'hFFFF);
    reg_rd(8'h6E, d); chk(d, e1, "strap word one held");
    reg_rd(8'h6F, d); chk(d, e2, "strap word two held");
  endtask

  task automatic t_skew;
    lane_a <= 4'h9;
    lane_b <= 4'h6;
    reg_rd(8'h55, d); chk(d, 16'h0069, "lane skew");
    reg_rd(8'h00, d); chk(d, 16'h0000, "unmapped read");
  endtask

  task automatic t_count;
    reg_rd(8'h71, d); chk(d, 16'h0000, "byte count reset");
    pulse(7, checker_evt_t'(3'b100));
    pulse(3, checker_evt_t'(3'b110));
    reg_rd(8'h71, d); chk(d, 16'h0000, "count before lock");
    reg_wr(8'h72, 16'h0001);
    reg_rd(8'h71, d); chk(d, 16'h000A, "locked bytes");
    reg_rd(8'h72, d); chk(d, 16'h0003, "locked errors");
    pulse(2, checker_evt_t'(3'b100));
    reg_rd(8'h71, d); chk(d, 16'h000A, "snapshot holds");
  endtask

  // Saturation, sticky flags, interrupt and lock-and-clear
  task automatic t_sat;
    wrap_sel <= 1'b0;
    pulse(65540, checker_evt_t'(3'b110));
    reg_wr(8'h72, 16'h0001);
    reg_rd(8'h71, d); chk(d, 16'hFFFF, "byte count saturates");
    reg_rd(8'h72, d); chk(d, 16'h02FF, "error sat and flag");
    reg_rd(8'h73, d); chk(d, 16'h0001, "irq status");
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    reg_wr(8'h74, 16'h0003);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    pulse(1, checker_evt_t'(3'b001));
    reg_rd(8'h72, d); chk(d, 16'h06FF, "packet flag");
    reg_wr(8'h72, 16'h0002);
    reg_rd(8'h72, d); chk(d, 16'h00FF, "flags cleared");
    reg_wr(8'h72, 16'h0001);
    reg_rd(8'h71, d); chk(d, 16'h0000, "bytes cleared");
    reg_rd(8'h72, d); chk(d, 16'h0000, "errors cleared");
    reg_wr(8'h73, 16'h0003);
    reg_rd(8'h73, d); chk(d, 16'h0000, "irq status cleared");
    repeat (2) @(negedge clk);
    chk({15'h0000, irq}, 16'h0000, "irq dropped");
  endtask

  // Error count wraps in wrap mode
  task automatic t_wrap;
    wrap_sel <= 1'b1;
    pulse(257, checker_evt_t'(3'b010));
    reg_wr(8'h72, 16'h0001);
    reg_rd(8'h72, d); chk(d, 16'h0001, "error count wraps");
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog about a fifth beyond the expected run length
  initial begin
    #(40 * 80000);
    err_count++;
    results;
  end

  // Main sequence
  initial begin
    err_count = 0;
    compares = 0;
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    s0 = strap_t'(22'h2D6B5A);
    straps = s0;
    lane_a = 4'h0;
    lane_b = 4'h0;
    evt = '0;
    wrap_sel = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_straps;
    t_skew;
    t_count;
    t_sat;
    t_wrap;
    results;
  end
endmodule // test_phy_status_regs
`default_nettype wire
